//--- rtl/mpw_pkg.sv
// constants and types shared by the pwm unit
package mpw_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'hae;
    localparam logic [7:0] ADDR_A_LOW = 8'hb1;
    localparam logic [7:0] ADDR_A_HIGH = 8'hb2;
    localparam logic [7:0] ADDR_B_LOW = 8'hb3;
    localparam logic [7:0] ADDR_B_HIGH = 8'hb4;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_MASK = 8'h7f;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_LSB = 4;
    localparam int PRESC_LSB = 2;
    localparam int CSRC_LSB = 0;
    localparam int PRESC_W = 6;
    localparam logic [5:0] DIV1_MASK = 6'h00;
    localparam logic [5:0] DIV4_MASK = 6'h03;
    localparam logic [5:0] DIV16_MASK = 6'h0f;
    localparam logic [5:0] DIV64_MASK = 6'h3f;
    localparam logic [15:0] RZ_HALF = 16'h8000;

    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_SINGLE16 = 3'h1,
        MODE_TWIN8 = 3'h2,
        MODE_TWIN16 = 3'h3,
        MODE_DENS16 = 3'h4,
        MODE_DUAL8 = 3'h5,
        MODE_RZ16 = 3'h6,
        MODE_HOLD = 3'h7
    } mpw_mode_t;

    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] presc;
        logic [1:0] csrc;
    } mpw_ctrl_t;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
    } mpw_pair_t;

    function automatic logic is_wide(input logic [2:0] m);
        return m == MODE_SINGLE16 || m == MODE_TWIN16 || m == MODE_DENS16 || m == MODE_RZ16;
    endfunction
endpackage

//--- rtl/mpw_tick.sv
// clock source select and prescaler producing one-cycle ticks
`timescale 1ns/100ps
module mpw_tick import mpw_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // control
    input wire logic clear,
    input wire logic [1:0] csrc,
    input wire logic [1:0] presc,
    // source enables, one cycle each
    input wire logic src_en [4],
    // prescaled tick
    output logic tick
);
    logic [PRESC_W-1:0] div_cnt, next_div_cnt;
    logic next_tick, src;
    logic [PRESC_W-1:0] lim;

    always_comb begin
        src = src_en[csrc];
        case (presc)
            2'h0: lim = DIV1_MASK;
            2'h1: lim = DIV4_MASK;
            2'h2: lim = DIV16_MASK;
            default: lim = DIV64_MASK;
        endcase
        next_div_cnt = div_cnt;
        next_tick = 1'b0;
        if (clear) begin
            next_div_cnt = '0;
        end else if (src) begin
            if (div_cnt >= lim) begin
                next_div_cnt = '0;
                next_tick = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick <= next_tick;
        end
    end

    a_tick_div1: assert property (@(posedge core_clk) disable iff (!rstn)
        (presc == 2'h0 && !clear && src && div_cnt == '0) |=> tick)
        else $error("undivided source did not tick");
endmodule // mpw_tick

//--- rtl/mpw_unit.sv
// multimode pwm unit: registers, counter and output generation
`timescale 1ns/100ps
module mpw_unit import mpw_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // clock source enables
    input wire logic crystal_clock_en,
    input wire logic slow_clock_en,
    input wire logic external_clock_pin,
    input wire logic pll_clock_en,
    // pins
    output logic first_output_pin,
    output logic second_output_pin,
    output logic pins_owned
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    mpw_ctrl_t pwm_control, next_pwm_control;
    mpw_pair_t shadow, next_shadow;   // software view
    mpw_pair_t active, next_active;   // in use by the counter
    logic pend, next_pend;
    logic [7:0] stage_a, stage_b, next_stage_a, next_stage_b;
    logic [15:0] count, next_count;
    logic [16:0] acc_a, acc_b, next_acc_a, next_acc_b;
    logic out_a, out_b, next_out_a, next_out_b;
    logic [7:0] next_rdata;
    logic ext_q, ctl_wr, tick, wrap, cycle_end;
    logic src_en [4];
    logic [15:0] period;
    logic wide;
    // dual 8 runs the full byte range, 256 counts per cycle
    localparam logic [15:0] DUAL8_PERIOD = 16'h0100;

    assign src_en[0] = crystal_clock_en;
    assign src_en[1] = slow_clock_en;
    assign src_en[2] = external_clock_pin & ~ext_q; // rising edge of pin
    assign src_en[3] = pll_clock_en;
    assign ctl_wr = sfr_wr && sfr_addr == ADDR_CONTROL;
    assign wide = is_wide(pwm_control.mode);

    mpw_tick u_tick (
        .core_clk(core_clk),
        .rstn(rstn),
        .clear(ctl_wr),
        .csrc(pwm_control.csrc),
        .presc(pwm_control.presc),
        .src_en(src_en),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // register writes and reads
    // ------------------------------------------------------------
    always_comb begin
        next_pwm_control = pwm_control;
        next_shadow = shadow;
        next_stage_a = stage_a;
        next_stage_b = stage_b;
        next_rdata = sfr_rdata;
        if (sfr_wr) begin
            case (sfr_addr)
                ADDR_CONTROL: next_pwm_control = mpw_ctrl_t'(sfr_wdata[6:0]);
                ADDR_A_LOW: begin
                    next_stage_a = sfr_wdata;
                    if (!wide) next_shadow.a[7:0] = sfr_wdata;
                end
                ADDR_B_LOW: begin
                    next_stage_b = sfr_wdata;
                    if (!wide) next_shadow.b[7:0] = sfr_wdata;
                end
                ADDR_A_HIGH: begin
                    next_shadow.a[15:8] = sfr_wdata;
                    if (wide) next_shadow.a[7:0] = stage_a;
                end
                ADDR_B_HIGH: begin
                    next_shadow.b[15:8] = sfr_wdata;
                    if (wide) next_shadow.b[7:0] = stage_b;
                end
                default: ;
            endcase
        end
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_CONTROL: next_rdata = {1'b0, pwm_control};
                ADDR_A_LOW: next_rdata = shadow.a[7:0];
                ADDR_A_HIGH: next_rdata = shadow.a[15:8];
                ADDR_B_LOW: next_rdata = shadow.b[7:0];
                ADDR_B_HIGH: next_rdata = shadow.b[15:8];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // counter and period
    // ------------------------------------------------------------
    always_comb begin
        case (pwm_control.mode)
            MODE_SINGLE16: period = active.b;
            MODE_TWIN8: period = {8'h00, active.b[7:0]};
            MODE_DUAL8: period = DUAL8_PERIOD;
            default: period = 16'hffff; // twin 16 counts the full range
        endcase
        wrap = tick && count >= period - 16'h0001 && period != 16'h0000;
        if (pwm_control.mode == MODE_TWIN16 || pwm_control.mode == MODE_DENS16
            || pwm_control.mode == MODE_RZ16) begin
            wrap = tick && count == 16'hffff;
        end
        cycle_end = wrap || pwm_control.mode == MODE_OFF || pwm_control.mode == MODE_HOLD;
        next_count = count;
        if (ctl_wr || pwm_control.mode == MODE_HOLD || pwm_control.mode == MODE_OFF) begin
            next_count = '0;
        end else if (wrap) begin
            next_count = '0;
        end else if (tick) begin
            next_count = count + 16'h0001;
        end
        next_pend = pend;
        next_active = active;
        if (cycle_end && pend) begin
            next_active = shadow;
            next_pend = 1'b0;
        end
        // a write landing on the commit cycle must not be lost
        if (next_shadow != shadow) next_pend = 1'b1;
    end

    // ------------------------------------------------------------
    // output generation
    // ------------------------------------------------------------
    always_comb begin
        next_out_a = out_a;
        next_out_b = out_b;
        next_acc_a = acc_a;
        next_acc_b = acc_b;
        case (pwm_control.mode)
            // compare against the pair of the coming cycle, so a commit shows from count 0
            MODE_SINGLE16: begin
                next_out_a = next_count < next_active.a;
                next_out_b = 1'b0;
            end
            MODE_TWIN16: begin
                next_out_a = next_count < next_active.a;
                next_out_b = next_count < next_active.b;
            end
            MODE_TWIN8: begin
                if (next_count == 16'h0000) next_out_a = 1'b1;
                if (next_count[7:0] == next_active.a[7:0]) next_out_a = 1'b0;
                if (next_count[7:0] == next_active.b[15:8]) next_out_b = 1'b1;
                if (next_count[7:0] == next_active.a[15:8]) next_out_b = 1'b0;
            end
            MODE_DUAL8: begin
                next_out_a = next_count[7:0] < next_active.a[7:0];
                next_out_b = next_count[7:0] < next_active.a[15:8];
            end
            MODE_DENS16, MODE_RZ16: begin
                if (tick) begin
                    next_acc_a = {1'b0, acc_a[15:0]} + {1'b0, active.a};
                    next_acc_b = {1'b0, acc_b[15:0]} + {1'b0, active.b};
                    next_out_a = next_acc_a[16];
                    next_out_b = next_acc_b[16];
                end else if (pwm_control.mode == MODE_RZ16 && count[0]) begin
                    next_out_a = 1'b0; // return to zero between ticks while the count is odd
                    next_out_b = 1'b0;
                end
            end
            default: begin
                next_out_a = 1'b0;
                next_out_b = 1'b0;
            end
        endcase
        if (ctl_wr) begin
            next_acc_a = '0;
            next_acc_b = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pwm_control <= mpw_ctrl_t'(CONTROL_RESET[6:0]);
            shadow <= '0;
            active <= '0;
            pend <= 1'b0;
            stage_a <= '0;
            stage_b <= '0;
            count <= '0;
            acc_a <= '0;
            acc_b <= '0;
            out_a <= 1'b0;
            out_b <= 1'b0;
            sfr_rdata <= '0;
            ext_q <= 1'b0;
            first_output_pin <= 1'b0;
            second_output_pin <= 1'b0;
            pins_owned <= 1'b0;
        end else begin
            pwm_control <= next_pwm_control;
            shadow <= next_shadow;
            active <= next_active;
            pend <= next_pend;
            stage_a <= next_stage_a;
            stage_b <= next_stage_b;
            count <= next_count;
            acc_a <= next_acc_a;
            acc_b <= next_acc_b;
            out_a <= next_out_a;
            out_b <= next_out_b;
            sfr_rdata <= next_rdata;
            ext_q <= external_clock_pin;
            first_output_pin <= next_out_a;
            second_output_pin <= next_out_b;
            pins_owned <= next_pwm_control.mode != MODE_OFF && next_pwm_control.mode != MODE_HOLD;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ctl_clears_cnt: assert property (@(posedge core_clk) disable iff (!rstn)
        ctl_wr |=> count == 16'h0000)
        else $error("control write left counter running");
    a_hold_keeps_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        pwm_control.mode == MODE_HOLD |=> count == 16'h0000)
        else $error("hold mode counter moved");
    a_low_staged: assert property (@(posedge core_clk) disable iff (!rstn)
        (sfr_wr && sfr_addr == ADDR_A_LOW && wide) |=> $stable(shadow.a))
        else $error("staged low byte leaked");
    a_commit_pair: assert property (@(posedge core_clk) disable iff (!rstn)
        (sfr_wr && sfr_addr == ADDR_B_HIGH && wide)
        |=> shadow.b == {$past(sfr_wdata), $past(stage_b)})
        else $error("high byte did not commit pair");
    a_active_on_end: assert property (@(posedge core_clk) disable iff (!rstn)
        (!$stable(active)) |-> $past(cycle_end))
        else $error("value applied mid cycle");
    a_count_step: assert property (@(posedge core_clk) disable iff (!rstn)
        (tick && !wrap && !ctl_wr && pwm_control.mode == MODE_TWIN16)
        |=> count == $past(count) + 16'h0001)
        else $error("counter did not advance");
    a_twin16_out: assert property (@(posedge core_clk) disable iff (!rstn)
        (pwm_control.mode == MODE_TWIN16 && $stable(pwm_control))
        |=> out_a == (count < active.a))
        else $error("twin output mismatch");
    a_off_low: assert property (@(posedge core_clk) disable iff (!rstn)
        pwm_control.mode == MODE_OFF |=> !out_a && !out_b)
        else $error("disabled outputs active");
    a_pin_follow: assert property (@(posedge core_clk) disable iff (!rstn)
        (pwm_control.mode == MODE_TWIN16 && $stable(pwm_control))
        |=> second_output_pin == (count < active.b))
        else $error("second pin differs from its channel");
endmodule // mpw_unit

//--- testbench/mpw_host.sv
// partner model: core software on the sfr bus and the pwm clock sources
`timescale 1ns/100ps
module mpw_host import mpw_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // sfr bus
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // clock sources
    output logic crystal_clock_en,
    output logic slow_clock_en,
    output logic external_clock_pin,
    output logic pll_clock_en
);
    int phase = 0;
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        crystal_clock_en = 1'b0;
        slow_clock_en = 1'b0;
        external_clock_pin = 1'b0;
        pll_clock_en = 1'b0;
    end
    // ------------------------------------------------------------
    // sources: fixed spacing so tick counts can be predicted
    // ------------------------------------------------------------
    always @(negedge core_clk) begin
        phase <= phase + 1;
        crystal_clock_en <= (phase % 15) == 14;
        slow_clock_en <= (phase % 7) == 6;
        external_clock_pin <= (phase % 6) >= 3;
        pll_clock_en <= 1'b1;
    end
    // ------------------------------------------------------------
    // bus cycles: a spare edge between strobes, never reassigned at once
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge core_clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask
    task automatic wr16(input logic [7:0] lo_addr, input logic [15:0] v);
        wr(lo_addr, v[7:0]);
        wr(lo_addr + 8'h01, v[15:8]);
    endtask
    // mode 0 first, so the pair takes effect at once
    task automatic load(input logic [15:0] a, input logic [15:0] b);
        wr(ADDR_CONTROL, 8'h00);
        wr16(ADDR_A_LOW, a);
        wr16(ADDR_B_LOW, b);
    endtask
endmodule // mpw_host

//--- testbench/tb_top.sv
// self-checking bench for the multimode pwm unit
`timescale 1ns/100ps
module tb_top import mpw_pkg::*;;
    typedef struct packed {
        logic [7:0] ctrl;
        logic owned;
        int lo;
        int hi;
    } mpw_row_t;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
    logic sfr_wr, sfr_rd, xen, sen, ext, pen, pin1, pin2, owned;
    int errors = 0;
    int n_checks = 0;
    int c1, c2;
    // a=3 b=5 loaded; counts tolerate unknown source phase
    mpw_row_t rows [14] = '{
        '{8'h83, 1'b0, 0, 0}, '{8'h33, 1'b1, 2, 5}, '{8'h37, 1'b1, 8, 14},
        '{8'h3b, 1'b1, 32, 50}, '{8'h3f, 1'b1, 128, 194}, '{8'h30, 1'b1, 30, 47},
        '{8'h31, 1'b1, 14, 23}, '{8'h32, 1'b1, 12, 20}, '{8'h13, 1'b1, 240, 240},
        '{8'h23, 1'b1, 240, 240}, '{8'h43, 1'b1, 0, 1}, '{8'h53, 1'b1, 6, 6},
        '{8'h63, 1'b1, 0, 1}, '{8'h73, 1'b0, 0, 0}};
    logic [7:0] addrs [6] = '{8'hae, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'haf};

    always #5 core_clk = ~core_clk;

    mpw_host mpw_host_i (.core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .crystal_clock_en(xen), .slow_clock_en(sen), .external_clock_pin(ext),
        .pll_clock_en(pen));
    mpw_unit mpw_unit_i (.core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .crystal_clock_en(xen), .slow_clock_en(sen), .external_clock_pin(ext),
        .pll_clock_en(pen), .first_output_pin(pin1), .second_output_pin(pin2),
        .pins_owned(owned));

    // ------------------------------------------------------------
    // checks and closing
    // ------------------------------------------------------------
    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_count(input string name, input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    task automatic count_high(input int n, output int h1, output int h2);
        h1 = 0;
        h2 = 0;
        repeat (n) begin
            @(negedge core_clk);
            h1 += (pin1 === 1'b1);
            h2 += (pin2 === 1'b1);
        end
    endtask
    task automatic test_done();
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // about 71k cycles of tests; margin before calling it a hang
    initial begin
        repeat (95000) @(posedge core_clk);
        errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(negedge core_clk);
        rstn = 1'b1;
        chk_byte("pins", 8'h00, {6'h00, pin2, pin1});
        chk_byte("owned", 8'h00, {7'h00, owned});
        foreach (addrs[i]) begin
            mpw_host_i.rd(addrs[i], d);
            chk_byte("reset read", 8'h00, d);
        end
        mpw_host_i.load(16'h0003, 16'h0005);
        foreach (rows[i]) begin
            mpw_host_i.wr(ADDR_CONTROL, rows[i].ctrl);
            count_high(400, c1, c2);
            if (rows[i].lo >= 0) begin
                chk_count("first pin high", rows[i].lo, rows[i].hi, c1);
            end
            chk_byte("owned", {7'h00, rows[i].owned}, {7'h00, owned});
            mpw_host_i.rd(ADDR_CONTROL, d);
            chk_byte("control", rows[i].ctrl & CONTROL_MASK, d);
        end
        // low byte is held back in a wide mode, shows at once in twin 8
        mpw_host_i.wr(ADDR_CONTROL, 8'h33);
        mpw_host_i.wr(ADDR_A_LOW, 8'h77);
        mpw_host_i.rd(ADDR_A_LOW, d);
        chk_byte("staged low", 8'h03, d);
        mpw_host_i.wr(ADDR_A_HIGH, 8'h00);
        mpw_host_i.rd(ADDR_A_LOW, d);
        chk_byte("committed low", 8'h77, d);
        mpw_host_i.wr16(ADDR_B_LOW, 16'h1234);
        mpw_host_i.rd(ADDR_B_HIGH, d);
        chk_byte("committed high", 8'h12, d);
        mpw_host_i.rd(ADDR_B_LOW, d);
        chk_byte("committed pair low", 8'h34, d);
        mpw_host_i.wr(ADDR_CONTROL, 8'h23);
        mpw_host_i.wr(ADDR_B_LOW, 8'h09);
        mpw_host_i.rd(ADDR_B_LOW, d);
        chk_byte("narrow low", 8'h09, d);
        // single mode: duty 2 of period 8, then duty 5 after commit
        mpw_host_i.load(16'h0002, 16'h0008);
        mpw_host_i.wr(ADDR_CONTROL, 8'h13);
        repeat (8) @(negedge core_clk);
        count_high(80, c1, c2);
        chk_count("single duty", 20, 20, c1);
        mpw_host_i.wr16(ADDR_A_LOW, 16'h0005);
        repeat (16) @(negedge core_clk);
        count_high(80, c1, c2);
        chk_count("single new duty", 50, 50, c1);
        // density: exact ones over any full 65536-tick window
        mpw_host_i.load(16'h0100, 16'h4010);
        mpw_host_i.wr(ADDR_CONTROL, 8'h43);
        repeat (4) @(negedge core_clk);
        count_high(65536, c1, c2);
        chk_count("density a", 256, 256, c1);
        chk_count("density b", 16400, 16400, c2);
        test_done();
    end
endmodule // tb_top
